/* rtcw_pkg.sv */
package rtcw_pkg;

	// ----------------------------------------------------------------
	// Register offsets of the timekeeping block
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_HSEC = 8'h00;
	localparam logic [7:0] ADDR_SEC = 8'h01;
	localparam logic [7:0] ADDR_MIN = 8'h02;
	localparam logic [7:0] ADDR_HOUR = 8'h03;
	localparam logic [7:0] ADDR_WDAY = 8'h04;
	localparam logic [7:0] ADDR_DATE = 8'h05;
	localparam logic [7:0] ADDR_MONTH = 8'h06;
	localparam logic [7:0] ADDR_YEAR = 8'h07;
	localparam logic [7:0] ADDR_WD_LO = 8'h08;
	localparam logic [7:0] ADDR_WD_HI = 8'h09;
	localparam logic [7:0] ADDR_CHARGE = 8'h0a;
	localparam logic [7:0] ADDR_FLAGS = 8'h0b;
	localparam logic [7:0] ADDR_CTRL = 8'h0c;

	// ----------------------------------------------------------------
	// Storable bits per time register, zero bits read back as zero
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_HSEC = 8'hff;
	localparam logic [7:0] MASK_SEC = 8'h7f;
	localparam logic [7:0] MASK_MIN = 8'h7f;
	localparam logic [7:0] MASK_HOUR = 8'h7f;
	localparam logic [7:0] MASK_WDAY = 8'h0f;
	localparam logic [7:0] MASK_DATE = 8'h3f;
	localparam logic [7:0] MASK_MONTH = 8'h3f;
	localparam logic [7:0] MASK_YEAR = 8'hff;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HOUR_MODE_BIT = 6;
	localparam int HOUR_PM_BIT = 5;
	localparam int FLAG_OSF_BIT = 7;
	localparam int FLAG_WF_BIT = 6;
	localparam int CTRL_EOSC_BIT = 7;
	localparam int CTRL_WDE_BIT = 1;
	localparam int CTRL_WDRST_BIT = 0;

	// ----------------------------------------------------------------
	// BCD limits
	// ----------------------------------------------------------------
	localparam logic [7:0] BCD_99 = 8'h99;
	localparam logic [7:0] BCD_59 = 8'h59;
	localparam logic [7:0] BCD_23 = 8'h23;
	localparam logic [7:0] BCD_12 = 8'h12;
	localparam logic [7:0] BCD_11 = 8'h11;
	localparam logic [7:0] BCD_07 = 8'h07;
	localparam logic [7:0] BCD_01 = 8'h01;
	localparam logic [7:0] BCD_00 = 8'h00;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [7:0] TIME_RESET = 8'h00;
	localparam logic [7:0] CHARGE_RESET = 8'h00;
	localparam logic [15:0] WD_RESET = 16'h0000;
	localparam logic OSF_RESET = 1'b1;
	localparam logic CTRL_BIT_RESET = 1'b0;

	// ----------------------------------------------------------------
	// Timebase: crystal divided to 4096 Hz, then 41 x24 and 40 x1
	// ----------------------------------------------------------------
	localparam logic [2:0] XTAL_DIV_LAST = 3'h7;
	localparam logic [5:0] PRE_LONG_DIV = 6'h29;
	localparam logic [5:0] PRE_SHORT_DIV = 6'h28;
	localparam logic [4:0] PRE_LAST_PERIOD = 5'h18;

	// ----------------------------------------------------------------
	// Supervisor reset pulse length
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int T_RST_US = 250000;
	localparam int RST_PULSE_CYC = T_RST_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Host request from the serial front end
	// ----------------------------------------------------------------
	typedef struct packed {
		logic start;
		logic ptr_load;
		logic wr;
		logic rd;
		logic [7:0] data;
	} rtcw_req_t;

endpackage

/* rtcw_core.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE1 - Divide 4096Hz by 41 x24, 40 x1
// RULE2 - Pattern completes every 250ms, exact 100Hz
// RULE3 - All counters hold packed BCD digits
// RULE4 - Date rolls at true month end, leap
// RULE5 - Weekday advances at midnight, 01 to 07
// RULE6 - Hours bit 6 selects 12-hour format
// RULE7 - 12-hour: bit 5 PM, hours 1-12
// RULE8 - 24-hour: bit 5 twenty digit, 00-23
// RULE9 - Host rewrites hours after format change
// RULE10 - General bits store, zero bits read zero
// RULE11 - Watchdog: BCD down-counter at 08h/09h
// RULE12 - Watchdog write loads counter and seed
// RULE13 - Watchdog read latches count, reloads seed
// RULE14 - Disabled watchdog is plain 16-bit storage
// RULE15 - All-zero load keeps watchdog stopped, flagless
// RULE16 - Enabled nonzero counter decrements, zero flags
// RULE17 - Expiry with drive pulses reset, blocks access
// RULE18 - Watchdog flag stays until host clears
// RULE19 - Any watchdog access reloads the countdown
// RULE20 - Host clears flag, enable before loading
// RULE21 - Pointer wraps from 0Ch to 00h
// RULE22 - Start or wrap copies time to shadow
// RULE23 - Flag bit 6 clears on zero only
// RULE24 - Tick ripples carries through calendar
// RULE25 - Time writes take effect immediately

module rtcw_core #(
	parameter int RST_PULSE_CYC = rtcw_pkg::RST_PULSE_CYC
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic xtal_clk,
	input rtcw_pkg::rtcw_req_t req,
	output logic [7:0] rdata,
	output logic access_ok,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe
);

	localparam int RCW = $clog2(RST_PULSE_CYC + 1);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// Returns {carry, next}: wraps to first after lim
	function automatic logic [8:0] bcd_inc(input logic [7:0] v,
			input logic [7:0] lim, input logic [7:0] first);
		logic [8:0] r;
		if (v == lim) begin
			r = {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			r = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			r = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
		return r;
	endfunction

	function automatic logic [15:0] bcd_dec(input logic [15:0] v);
		logic [15:0] r;
		logic borrow;
		r = v;
		borrow = 1'b1;
		for (int i = 0; i < 4; i++) begin
			if (borrow) begin
				if (r[i*4 +: 4] == 4'h0) begin
					r[i*4 +: 4] = 4'h9;
				end else begin
					r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
					borrow = 1'b0;
				end
			end
		end
		return r;
	endfunction

	// Last day of a month in BCD, leap February from year digits
	function automatic logic [7:0] month_last(input logic [4:0] m,
			input logic [7:0] y);
		logic leap;
		logic [7:0] r;
		leap = y[4] ? (y[1:0] == 2'b10) : (y[1:0] == 2'b00);
		case (m)
			5'h02: r = leap ? 8'h29 : 8'h28;
			5'h04, 5'h06, 5'h09, 5'h11: r = 8'h30;
			default: r = 8'h31;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Crystal domain: 4096 Hz toggle
	// ----------------------------------------------------------------
	logic xrst_s1_q;
	logic xrst_s2_q;
	logic [2:0] xdiv_q;
	logic xtog_q;

	always_ff @(posedge xtal_clk) begin
		xrst_s1_q <= srst;
		xrst_s2_q <= xrst_s1_q;
	end

	always_ff @(posedge xtal_clk) begin
		if (xrst_s2_q) begin
			xdiv_q <= 3'h0;
			xtog_q <= 1'b0;
		end else begin
			xdiv_q <= xdiv_q + 3'h1;
			if (xdiv_q == rtcw_pkg::XTAL_DIV_LAST) begin
				xtog_q <= ~xtog_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Crossings into the reference domain
	// ----------------------------------------------------------------
	logic tog_s1_q;
	logic tog_s2_q;
	logic tog_s3_q;
	logic pin_s1_q;
	logic pin_s2_q;
	logic tick4k;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tog_s1_q <= 1'b0;
			tog_s2_q <= 1'b0;
			tog_s3_q <= 1'b0;
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
		end else if (ce) begin
			tog_s1_q <= xtog_q;
			tog_s2_q <= tog_s1_q;
			tog_s3_q <= tog_s2_q;
			pin_s1_q <= reset_pin_in;
			pin_s2_q <= pin_s1_q;
		end
	end

	assign tick4k = tog_s2_q ^ tog_s3_q;

	// ----------------------------------------------------------------
	// Hundredths prescaler
	// ----------------------------------------------------------------
	logic [5:0] div_q;
	logic [4:0] per_q;
	logic tick_q;
	logic [5:0] div_lim;

	// Last of 25 periods is the short one; the set spans 1024 ticks
	assign div_lim = (per_q == rtcw_pkg::PRE_LAST_PERIOD) ?
		rtcw_pkg::PRE_SHORT_DIV : rtcw_pkg::PRE_LONG_DIV; // RULE1

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			div_q <= 6'h00;
			per_q <= 5'h00;
			tick_q <= 1'b0;
		end else if (ce) begin
			tick_q <= 1'b0;
			if (tick4k) begin
				if (div_q == div_lim - 6'h01) begin
					div_q <= 6'h00;
					tick_q <= 1'b1;
					if (per_q == rtcw_pkg::PRE_LAST_PERIOD) begin
						per_q <= 5'h00; // RULE2
					end else begin
						per_q <= per_q + 5'h01;
					end
				end else begin
					div_q <= div_q + 6'h01;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Host access and pointer
	// ----------------------------------------------------------------
	logic [RCW-1:0] rst_cnt_q;
	logic rst_active;
	logic [7:0] ptr_q;
	logic [7:0] ptr_next;
	logic wr_en;
	logic rd_en;
	logic wd_hit;
	logic snap;

	assign rst_active = (rst_cnt_q != '0);
	assign access_ok = ~rst_active & pin_s2_q; // RULE17
	assign wr_en = req.wr & access_ok;
	assign rd_en = req.rd & access_ok;
	assign wd_hit = (ptr_q == rtcw_pkg::ADDR_WD_LO) ||
		(ptr_q == rtcw_pkg::ADDR_WD_HI);
	assign ptr_next = (ptr_q == rtcw_pkg::ADDR_CTRL) ?
		rtcw_pkg::ADDR_HSEC : ptr_q + 8'h01; // RULE21
	assign snap = access_ok & (req.start | ((req.wr | req.rd) &
		(ptr_q == rtcw_pkg::ADDR_CTRL))); // RULE22

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ptr_q <= rtcw_pkg::ADDR_HSEC;
		end else if (ce) begin
			if (access_ok && req.ptr_load) begin
				ptr_q <= req.data;
			end else if (wr_en || rd_en) begin
				ptr_q <= ptr_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Time and calendar counters
	// ----------------------------------------------------------------
	logic [7:0] tm_q [8];
	logic [7:0] tm_d [8];
	logic [7:0] shd_q [8];
	logic [7:0] wmask [8];

	assign wmask[0] = rtcw_pkg::MASK_HSEC;
	assign wmask[1] = rtcw_pkg::MASK_SEC;
	assign wmask[2] = rtcw_pkg::MASK_MIN;
	assign wmask[3] = rtcw_pkg::MASK_HOUR;
	assign wmask[4] = rtcw_pkg::MASK_WDAY;
	assign wmask[5] = rtcw_pkg::MASK_DATE;
	assign wmask[6] = rtcw_pkg::MASK_MONTH;
	assign wmask[7] = rtcw_pkg::MASK_YEAR;

	always_comb begin
		logic [8:0] r;
		logic [7:0] hr;
		logic c;
		r = '0;
		hr = '0;
		c = 1'b0;
		for (int i = 0; i < 8; i++) begin
			tm_d[i] = tm_q[i];
		end
		r = bcd_inc(tm_q[0], rtcw_pkg::BCD_99, rtcw_pkg::BCD_00); // RULE24
		tm_d[0] = r[7:0];
		if (r[8]) begin
			r = bcd_inc(tm_q[1], rtcw_pkg::BCD_59, rtcw_pkg::BCD_00);
			tm_d[1] = r[7:0];
		end
		if (r[8]) begin
			r = bcd_inc(tm_q[2], rtcw_pkg::BCD_59, rtcw_pkg::BCD_00);
			tm_d[2] = r[7:0];
		end
		if (r[8]) begin
			if (tm_q[3][rtcw_pkg::HOUR_MODE_BIT]) begin // RULE6
				hr = {3'b000, tm_q[3][4:0]};
				c = 1'b0;
				if (hr == rtcw_pkg::BCD_12) begin
					hr = rtcw_pkg::BCD_01;
				end else if (hr == rtcw_pkg::BCD_11) begin
					hr = rtcw_pkg::BCD_12;
					c = tm_q[3][rtcw_pkg::HOUR_PM_BIT];
				end else begin
					r = bcd_inc(hr, rtcw_pkg::BCD_12, rtcw_pkg::BCD_01);
					hr = r[7:0];
				end
				tm_d[3] = {tm_q[3][7:6],
					tm_q[3][rtcw_pkg::HOUR_PM_BIT] ^
					(hr == rtcw_pkg::BCD_12), hr[4:0]}; // RULE7
				r = {c, 8'h00};
			end else begin
				r = bcd_inc({2'b00, tm_q[3][5:0]}, rtcw_pkg::BCD_23,
					rtcw_pkg::BCD_00); // RULE8
				tm_d[3] = {tm_q[3][7:6], r[5:0]};
			end
		end
		if (r[8]) begin
			r = bcd_inc({5'h00, tm_q[4][2:0]}, rtcw_pkg::BCD_07,
				rtcw_pkg::BCD_01);
			tm_d[4] = {tm_q[4][7:3], r[2:0]}; // RULE5
			r = bcd_inc({2'b00, tm_q[5][5:0]},
				month_last(tm_q[6][4:0], tm_q[7]),
				rtcw_pkg::BCD_01); // RULE4
			tm_d[5] = {tm_q[5][7:6], r[5:0]};
		end
		if (r[8]) begin
			r = bcd_inc({3'b000, tm_q[6][4:0]}, rtcw_pkg::BCD_12,
				rtcw_pkg::BCD_01);
			tm_d[6] = {tm_q[6][7:5], r[4:0]};
		end
		if (r[8]) begin
			r = bcd_inc(tm_q[7], rtcw_pkg::BCD_99, rtcw_pkg::BCD_00);
			tm_d[7] = r[7:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < 8; i++) begin
				tm_q[i] <= rtcw_pkg::TIME_RESET;
			end
		end else if (ce) begin
			if (wr_en && ptr_q < rtcw_pkg::ADDR_WD_LO) begin
				tm_q[ptr_q[2:0]] <= req.data & wmask[ptr_q[2:0]]; // RULE25
			end else if (tick_q) begin
				for (int i = 0; i < 8; i++) begin
					tm_q[i] <= tm_d[i] & wmask[i]; // RULE3
				end
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			for (int i = 0; i < 8; i++) begin
				shd_q[i] <= rtcw_pkg::TIME_RESET;
			end
		end else if (ce && snap) begin
			for (int i = 0; i < 8; i++) begin
				shd_q[i] <= tm_q[i]; // RULE22
			end
		end
	end

	// ----------------------------------------------------------------
	// Control, flags and charge path storage
	// ----------------------------------------------------------------
	logic eosc_q;
	logic wde_q;
	logic wdrst_q;
	logic osf_q;
	logic wf_q;
	logic [7:0] charge_q;
	logic wd_expire;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			eosc_q <= rtcw_pkg::CTRL_BIT_RESET;
			wde_q <= rtcw_pkg::CTRL_BIT_RESET;
			wdrst_q <= rtcw_pkg::CTRL_BIT_RESET;
			charge_q <= rtcw_pkg::CHARGE_RESET;
		end else if (ce && wr_en) begin
			if (ptr_q == rtcw_pkg::ADDR_CTRL) begin
				eosc_q <= req.data[rtcw_pkg::CTRL_EOSC_BIT];
				wde_q <= req.data[rtcw_pkg::CTRL_WDE_BIT];
				wdrst_q <= req.data[rtcw_pkg::CTRL_WDRST_BIT];
			end
			if (ptr_q == rtcw_pkg::ADDR_CHARGE) begin
				charge_q <= req.data; // RULE10
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			osf_q <= rtcw_pkg::OSF_RESET;
			wf_q <= 1'b0;
		end else if (ce) begin
			if (wd_expire) begin
				wf_q <= 1'b1; // RULE18
			end else if (wr_en && ptr_q == rtcw_pkg::ADDR_FLAGS &&
					!req.data[rtcw_pkg::FLAG_WF_BIT]) begin
				wf_q <= 1'b0; // RULE23
			end
			if (wr_en && ptr_q == rtcw_pkg::ADDR_FLAGS &&
					!req.data[rtcw_pkg::FLAG_OSF_BIT]) begin
				osf_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Watchdog counter
	// ----------------------------------------------------------------
	logic [15:0] wd_cnt_q;
	logic [15:0] wd_seed_q;
	logic wd_access;

	assign wd_access = (wr_en | rd_en) & wd_hit;
	// Counter at zero never runs, so an all-zero load stays silent
	assign wd_expire = ce & wde_q & tick_q & ~wd_access &
		(wd_cnt_q == 16'h0001); // RULE15 RULE16

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			wd_cnt_q <= rtcw_pkg::WD_RESET;
			wd_seed_q <= rtcw_pkg::WD_RESET;
		end else if (ce) begin
			if (wr_en && ptr_q == rtcw_pkg::ADDR_WD_LO) begin
				wd_seed_q[7:0] <= req.data; // RULE12
				wd_cnt_q <= {wd_seed_q[15:8], req.data};
			end else if (wr_en && ptr_q == rtcw_pkg::ADDR_WD_HI) begin
				wd_seed_q[15:8] <= req.data; // RULE12
				wd_cnt_q <= {req.data, wd_seed_q[7:0]};
			end else if (rd_en && wd_hit) begin
				wd_cnt_q <= wd_seed_q; // RULE13 RULE19
			end else if (wde_q && tick_q && wd_cnt_q != 16'h0000) begin
				wd_cnt_q <= bcd_dec(wd_cnt_q); // RULE11 RULE14
			end
		end
	end

	// ----------------------------------------------------------------
	// Supervisor reset pulse
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rst_cnt_q <= '0;
		end else if (ce) begin
			if (wd_expire && wdrst_q) begin
				rst_cnt_q <= RCW'(RST_PULSE_CYC); // RULE17
			end else if (rst_active) begin
				rst_cnt_q <= rst_cnt_q - RCW'(1);
			end
		end
	end

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = rst_active;

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	logic [7:0] rd_mux;

	always_comb begin
		rd_mux = 8'h00;
		if (ptr_q < rtcw_pkg::ADDR_WD_LO) begin
			rd_mux = shd_q[ptr_q[2:0]];
		end else begin
			case (ptr_q)
				rtcw_pkg::ADDR_WD_LO: rd_mux = wd_cnt_q[7:0];
				rtcw_pkg::ADDR_WD_HI: rd_mux = wd_cnt_q[15:8];
				rtcw_pkg::ADDR_CHARGE: rd_mux = charge_q;
				rtcw_pkg::ADDR_FLAGS: rd_mux = {osf_q, wf_q, 6'h00};
				rtcw_pkg::ADDR_CTRL: rd_mux = {eosc_q, 5'h00, wde_q, wdrst_q};
				default: rd_mux = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rdata <= 8'h00;
		end else if (ce && rd_en) begin
			rdata <= rd_mux; // RULE13
		end
	end

endmodule

/* rtcw_core_chk.sv */
`timescale 1ns/1ps
module rtcw_core_chk #(
	parameter int RST_PULSE_CYC = 20
) (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic ce,
	input wire logic xtal_clk,
	input rtcw_pkg::rtcw_req_t req,
	input wire logic [7:0] rdata,
	input wire logic access_ok,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);

	// ----------------------------------------------------------------
	// Pointer tracking and pulse length counter
	// ----------------------------------------------------------------
	logic acc;
	logic rd_ok;
	logic [7:0] ptr_q;
	logic [7:0] mask_q;
	int unsigned oe_cnt_q;
	assign acc = ce && access_ok;
	assign rd_ok = acc && req.rd && !req.ptr_load;

	function automatic logic [7:0] rd_mask(input logic [7:0] a);
		case (a)
			8'h01, 8'h02, 8'h03: return 8'h7f;
			8'h04: return 8'h0f;
			8'h05, 8'h06: return 8'h3f;
			8'h0b: return 8'hc0;
			8'h0c: return 8'h83;
			default: return (a > 8'h0c) ? 8'h00 : 8'hff;
		endcase
	endfunction

	always_ff @(posedge ref_clk) begin
		if (srst)
			ptr_q <= 8'h00;
		else if (acc && req.ptr_load)
			ptr_q <= req.data;
		else if (acc && (req.rd || req.wr))
			ptr_q <= (ptr_q == 8'h0c) ? 8'h00 : ptr_q + 8'h01;
	end

	always_ff @(posedge ref_clk) begin
		if (rd_ok)
			mask_q <= rd_mask(ptr_q);
	end

	always_ff @(posedge ref_clk) begin
		if (srst || !reset_pin_oe)
			oe_cnt_q <= 0;
		else
			oe_cnt_q <= oe_cnt_q + 1;
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	property p_zero_bits;
		rd_ok |=> (rdata & ~mask_q) == 8'h00;
	endproperty
	a_zero_bits: assert property (p_zero_bits)
		else $error("fixed zero bit read as one");

	property p_bcd;
		rd_ok && ptr_q <= 8'h09 && ptr_q != 8'h03
			|=> rdata[3:0] <= 4'h9 && rdata[7:4] <= 4'h9;
	endproperty
	a_bcd: assert property (p_bcd)
		else $error("count read back is not bcd");

	property p_hold;
		!rd_ok |=> $stable(rdata);
	endproperty
	a_hold: assert property (p_hold)
		else $error("read data moved without a read");

	property p_pin_out;
		reset_pin_out == 1'b0;
	endproperty
	a_pin_out: assert property (p_pin_out)
		else $error("open drain output drives high");

	property p_block;
		reset_pin_oe |-> !access_ok;
	endproperty
	a_block: assert property (p_block)
		else $error("access allowed during reset pulse");

	property p_pin_low;
		!reset_pin_in [*3] |-> !access_ok;
	endproperty
	a_pin_low: assert property (p_pin_low)
		else $error("access allowed while reset wire low");

	property p_pulse_len;
		$fell(reset_pin_oe) |-> oe_cnt_q == RST_PULSE_CYC;
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("reset pulse length wrong");

	property p_reset_state;
		@(posedge ref_clk) disable iff (1'b0)
			srst |=> rdata == 8'h00 && !reset_pin_oe;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("outputs not cleared by reset");

	c_pulse: cover property ($rose(reset_pin_oe));
	c_refused: cover property (req.wr && !access_ok);
	c_flag_read: cover property (rd_ok && ptr_q == 8'h0b);
endmodule

bind rtcw_core rtcw_core_chk #(.RST_PULSE_CYC(RST_PULSE_CYC)) u_chk (
	.ref_clk(ref_clk),
	.srst(srst),
	.ce(ce),
	.xtal_clk(xtal_clk),
	.req(req),
	.rdata(rdata),
	.access_ok(access_ok),
	.reset_pin_in(reset_pin_in),
	.reset_pin_out(reset_pin_out),
	.reset_pin_oe(reset_pin_oe)
);

/* rtcw_pin_model.sv */
`timescale 1ns/1ps
module rtcw_pin_model (
	input wire logic drive_oe,
	input wire logic drive_val,
	input wire logic button_n,
	output logic pin
);
	// Open-drain wire with pull-up: any low driver wins
	assign pin = ((drive_oe && !drive_val) || !button_n) ? 1'b0 : 1'b1;
endmodule

/* rtc_calendar_watchdog_bench.sv */
`timescale 1ns/1ps
module rtc_calendar_watchdog_bench;
	logic ref_clk = 1'b0;
	logic xtal_clk = 1'b0;
	logic srst = 1'b1;
	logic ce = 1'b1;
	logic button_n = 1'b1;
	rtcw_pkg::rtcw_req_t req = '0;
	logic [7:0] rdata;
	logic [7:0] v;
	logic access_ok, pin, pin_out, pin_oe;
	logic [63:0] wv;
	logic [79:0] tc [7];
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	int i, j, n;

	initial forever #5 ref_clk = ~ref_clk;
	initial begin
		#3;
		forever #6 xtal_clk = ~xtal_clk;
	end

	rtcw_core #(.RST_PULSE_CYC(20)) uut (
		.ref_clk(ref_clk),
		.srst(srst),
		.ce(ce),
		.xtal_clk(xtal_clk),
		.req(req),
		.rdata(rdata),
		.access_ok(access_ok),
		.reset_pin_in(pin),
		.reset_pin_out(pin_out),
		.reset_pin_oe(pin_oe)
	);

	rtcw_pin_model wire_model (
		.drive_oe(pin_oe),
		.drive_val(pin_out),
		.button_n(button_n),
		.pin(pin)
	);

	// ----------------------------------------------------------------
	// Host access and checking tasks
	// ----------------------------------------------------------------
	task automatic op(input logic [3:0] s, input logic [7:0] d);
		@(negedge ref_clk);
		req = {s, d};
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		op(4'h4, a);
		op(4'h2, d);
		op(4'h0, 8'h00);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		op(4'h4, a);
		op(4'h1, 8'h00);
		op(4'h0, 8'h00);
		d = rdata;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic rng(input logic [7:0] got, input logic [7:0] lo,
		input logic [7:0] hi);
		tests_run++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			error_cnt++;
			$display("wrong value at %0t: got %h out of range", $time, got);
		end
	endtask

	task automatic fin(input string s);
		$display("test %s done", s);
	endtask

	task automatic results;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			results();
		end
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		// hour day date month year, then expected after the next hour rollover
		tc[0] = 80'h23_07_28_02_03_00_01_01_03_03;
		tc[1] = 80'h23_03_28_02_04_00_04_29_02_04;
		tc[2] = 80'h23_01_30_04_99_00_02_01_05_99;
		tc[3] = 80'h23_05_31_12_99_00_06_01_01_00;
		tc[4] = 80'h71_02_31_01_05_52_03_01_02_05;
		tc[5] = 80'h51_02_15_06_05_72_02_15_06_05;
		tc[6] = 80'h19_04_10_10_10_20_04_10_10_10;
		repeat (6) @(negedge ref_clk);
		srst = 1'b0;
		for (i = 1; i < 14; i++) begin
			rd(i[7:0], v);
			chk(v, (i == 11) ? 8'h80 : 8'h00);
		end
		wr(8'h0a, 8'ha5);
		rd(8'h0a, v);
		chk(v, 8'ha5);
		wr(8'h0c, 8'hff);
		rd(8'h0c, v);
		chk(v, 8'h83);
		wr(8'h0c, 8'h00);
		wr(8'h0b, 8'hff);
		rd(8'h0b, v);
		chk(v, 8'h80);
		fin("registers");
		wr(8'h00, 8'h00);
		repeat (9830) @(negedge ref_clk);
		op(4'h8, 8'h00);
		rd(8'h00, v);
		rng(v, 8'h24, 8'h26);
		fin("prescaler");
		for (i = 0; i < 7; i++) begin
			wv = {8'h98, 8'h59, 8'h59, tc[i][79:40]};
			op(4'h4, 8'h00);
			for (j = 0; j < 8; j++)
				op(4'h2, wv[8*(7-j)+:8]);
			op(4'h0, 8'h00);
			repeat (1300) @(negedge ref_clk);
			op(4'h8, 8'h00);
			rd(8'h01, v);
			chk(v, 8'h00);
			rd(8'h02, v);
			chk(v, 8'h00);
			for (j = 0; j < 5; j++) begin
				rd(8'h03 + j[7:0], v);
				chk(v, tc[i][8*(4-j)+:8]);
			end
		end
		fin("calendar");
		op(4'h4, 8'h0c);
		op(4'h2, 8'h00);
		op(4'h2, 8'h50);
		op(4'h8, 8'h00);
		op(4'h0, 8'h00);
		repeat (800) @(negedge ref_clk);
		rd(8'h00, v);
		rng(v, 8'h50, 8'h51);
		op(4'h8, 8'h00);
		rd(8'h00, v);
		rng(v, 8'h52, 8'h53);
		fin("wrap");
		wr(8'h08, 8'h34);
		wr(8'h09, 8'h12);
		repeat (1000) @(negedge ref_clk);
		rd(8'h08, v);
		chk(v, 8'h34);
		rd(8'h09, v);
		chk(v, 8'h12);
		wr(8'h0b, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h00);
		wr(8'h0c, 8'h02);
		repeat (1500) @(negedge ref_clk);
		rd(8'h0b, v);
		chk(v, 8'h00);
		wr(8'h0c, 8'h00);
		wr(8'h08, 8'h03);
		wr(8'h09, 8'h00);
		wr(8'h0c, 8'h02);
		for (i = 0; i < 10; i++) begin
			repeat (200) @(negedge ref_clk);
			rd(8'h08, v);
			rng(v, 8'h02, 8'h03);
		end
		rd(8'h0b, v);
		chk(v, 8'h00);
		repeat (2000) @(negedge ref_clk);
		rd(8'h0b, v);
		chk(v, 8'h40);
		repeat (500) @(negedge ref_clk);
		wr(8'h0b, 8'hff);
		rd(8'h0b, v);
		chk(v, 8'h40);
		wr(8'h0b, 8'h00);
		rd(8'h0b, v);
		chk(v, 8'h00);
		wr(8'h0c, 8'h00);
		wr(8'h08, 8'h00);
		wr(8'h09, 8'h01);
		wr(8'h0c, 8'h02);
		repeat (2000) @(negedge ref_clk);
		rd(8'h08, v);
		rng(v, 8'h93, 8'h96);
		fin("watchdog");
		wr(8'h0c, 8'h00);
		wr(8'h08, 8'h02);
		wr(8'h09, 8'h00);
		wr(8'h0c, 8'h03);
		for (n = 0; n < 2000 && pin_oe !== 1'b1; n++)
			@(negedge ref_clk);
		chk({7'h00, access_ok}, 8'h00);
		wr(8'h0a, 8'h11);
		for (n = 0; n < 100 && pin_oe !== 1'b0; n++)
			@(negedge ref_clk);
		repeat (4) @(negedge ref_clk);
		rd(8'h0a, v);
		chk(v, 8'ha5);
		rd(8'h0b, v);
		chk(v, 8'h40);
		button_n = 1'b0;
		repeat (4) @(negedge ref_clk);
		chk({7'h00, access_ok}, 8'h00);
		button_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk({7'h00, access_ok}, 8'h01);
		fin("reset drive");
		ce = 1'b0;
		op(4'h1, 8'h00);
		op(4'h0, 8'h00);
		ce = 1'b1;
		chk(rdata, v);
		fin("clock enable");
		results();
	end
endmodule
